// File: fault_sup_pkg.sv
// Package with constants and carriers for the predriver fault supervisor
package fault_sup_pkg;
	// ==========================================================
	// Counts and timing
	localparam int CHANNELS = 4;
	localparam int CLK_MHZ = 100;
	localparam int FAULT_MASK_TIME_US = 60;
	localparam int SHORT_DEGLITCH_TIME_US = 8;
	localparam int RETRY_PERIOD_MS = 10;
	localparam int RETRY_PULSE_WIDTH_US = 68;
	localparam int FAULT_MASK_CYC = FAULT_MASK_TIME_US * CLK_MHZ;
	localparam int SHORT_DEGLITCH_CYC = SHORT_DEGLITCH_TIME_US * CLK_MHZ;
	localparam int RETRY_PERIOD_CYC = RETRY_PERIOD_MS * 1000 * CLK_MHZ;
	localparam int RETRY_PULSE_WIDTH_CYC = RETRY_PULSE_WIDTH_US * CLK_MHZ;
	localparam int CNT_W = 20;
	localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
	localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
	// ==========================================================
	// Variants
	localparam logic VARIANT_LATCH = 1'h0;
	localparam logic VARIANT_RETRY = 1'h1;
	// ==========================================================
	// Channel states
	typedef enum logic [2:0] {
		CH_OFF_MASK,
		CH_OFF_WATCH,
		CH_ON_MASK,
		CH_ON_WATCH,
		CH_LATCHED,
		CH_RETRY
	} ch_state_t;
	// Per-channel command, drain sense and battery control inputs
	typedef struct packed {
		logic cmd_on;
		logic drain_high;
		logic inhibit;
		logic report_en;
	} ch_in_t;
	// Per-channel results
	typedef struct packed {
		logic gate_out;
		logic fault;
	} ch_out_t;
endpackage : fault_sup_pkg

// File: fault_channel.sv
// One channel of mask, deglitch, latch and retry logic
`timescale 1ns/1ps
`default_nettype none
module fault_channel #(
	parameter logic VARIANT = fault_sup_pkg::VARIANT_LATCH,
	parameter int MASK_CYC = fault_sup_pkg::FAULT_MASK_CYC,
	parameter int DEGLITCH_CYC = fault_sup_pkg::SHORT_DEGLITCH_CYC,
	parameter int RETRY_PERIOD_CYC = fault_sup_pkg::RETRY_PERIOD_CYC,
	parameter int RETRY_PULSE_CYC = fault_sup_pkg::RETRY_PULSE_WIDTH_CYC
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire fault_sup_pkg::ch_in_t i_ch,
	output var fault_sup_pkg::ch_out_t o_ch
);
	localparam int CW = fault_sup_pkg::CNT_W;
	localparam logic [CW-1:0] MASK_LAST = CW'(MASK_CYC - 1);
	localparam logic [CW-1:0] DG_LAST = CW'(DEGLITCH_CYC - 1);
	localparam logic [CW-1:0] RP_LAST = CW'(RETRY_PERIOD_CYC - 1);
	localparam logic [CW-1:0] RW_LAST = CW'(RETRY_PULSE_CYC - 1);

	fault_sup_pkg::ch_state_t state_r, state_nxt;
	logic [fault_sup_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic [fault_sup_pkg::CNT_W-1:0] dg_r, dg_nxt;
	logic fault_r, fault_nxt;

	// ==========================================================
	// Next state
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r + fault_sup_pkg::CNT_ONE;
		dg_nxt = fault_sup_pkg::CNT_ZERO;
		fault_nxt = fault_r;
		case (state_r)
			fault_sup_pkg::CH_OFF_MASK: begin
				// Open-load ignored in the blanking window
				fault_nxt = 1'b0; // [RULE_11]
				if (i_ch.cmd_on && !i_ch.inhibit) begin
					state_nxt = fault_sup_pkg::CH_ON_MASK; // [RULE_01]
					cnt_nxt = fault_sup_pkg::CNT_ZERO;
				end else if (cnt_r >= MASK_LAST) begin
					state_nxt = fault_sup_pkg::CH_OFF_WATCH;
				end
			end
			fault_sup_pkg::CH_OFF_WATCH: begin
				// Low drain while off means open load; live status only
				fault_nxt = !i_ch.drain_high && i_ch.report_en; // [RULE_10] [RULE_12] [RULE_15]
				cnt_nxt = cnt_r;
				if (i_ch.cmd_on && !i_ch.inhibit) begin
					state_nxt = fault_sup_pkg::CH_ON_MASK; // [RULE_01]
					cnt_nxt = fault_sup_pkg::CNT_ZERO;
					fault_nxt = 1'b0;
				end
			end
			fault_sup_pkg::CH_ON_MASK: begin
				fault_nxt = 1'b0;
				if (!i_ch.cmd_on || i_ch.inhibit) begin
					state_nxt = fault_sup_pkg::CH_OFF_MASK; // [RULE_11]
					cnt_nxt = fault_sup_pkg::CNT_ZERO;
				end else if (cnt_r >= MASK_LAST) begin
					state_nxt = fault_sup_pkg::CH_ON_WATCH; // [RULE_01]
				end
			end
			fault_sup_pkg::CH_ON_WATCH: begin
				cnt_nxt = cnt_r;
				// Deglitch restarts on any drop so only a steady short counts
				if (i_ch.drain_high && i_ch.report_en) begin
					dg_nxt = dg_r + fault_sup_pkg::CNT_ONE; // [RULE_03]
				end
				if (!i_ch.cmd_on || i_ch.inhibit) begin
					state_nxt = fault_sup_pkg::CH_OFF_MASK; // [RULE_11]
					cnt_nxt = fault_sup_pkg::CNT_ZERO;
				end else if (i_ch.drain_high && i_ch.report_en && dg_r >= DG_LAST) begin
					fault_nxt = 1'b1; // [RULE_02]
					cnt_nxt = fault_sup_pkg::CNT_ZERO;
					state_nxt = (VARIANT == fault_sup_pkg::VARIANT_RETRY) ?
						fault_sup_pkg::CH_RETRY : fault_sup_pkg::CH_LATCHED; // [RULE_04] [RULE_06]
				end
			end
			fault_sup_pkg::CH_LATCHED: begin
				cnt_nxt = cnt_r;
				// Only an off command releases the latch
				if (!i_ch.cmd_on) begin
					state_nxt = fault_sup_pkg::CH_OFF_MASK; // [RULE_05]
					cnt_nxt = fault_sup_pkg::CNT_ZERO;
					fault_nxt = 1'b0; // [RULE_05]
				end
			end
			fault_sup_pkg::CH_RETRY: begin
				if (cnt_r >= RP_LAST) begin
					cnt_nxt = fault_sup_pkg::CNT_ZERO; // [RULE_07]
				end
				if (!i_ch.cmd_on || i_ch.inhibit) begin
					state_nxt = fault_sup_pkg::CH_OFF_MASK; // [RULE_06]
					cnt_nxt = fault_sup_pkg::CNT_ZERO;
					fault_nxt = 1'b0;
				end else if (cnt_r == RW_LAST && !i_ch.drain_high) begin
					// Drain sampled at the end of each pulse decides recovery
					state_nxt = fault_sup_pkg::CH_ON_WATCH; // [RULE_08]
					fault_nxt = 1'b0; // [RULE_08]
				end
			end
			default: begin
				state_nxt = fault_sup_pkg::CH_OFF_MASK;
				cnt_nxt = fault_sup_pkg::CNT_ZERO;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_r <= fault_sup_pkg::CH_OFF_MASK;
			cnt_r <= fault_sup_pkg::CNT_ZERO;
			dg_r <= fault_sup_pkg::CNT_ZERO;
			fault_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			dg_r <= dg_nxt;
			fault_r <= fault_nxt;
		end
	end

	// Gate is registered by the top from this combinational view
	always_comb begin
		o_ch.fault = fault_r;
		case (state_r)
			fault_sup_pkg::CH_ON_MASK, fault_sup_pkg::CH_ON_WATCH: o_ch.gate_out = !i_ch.inhibit;
			// Pulse covers counts 0 up to and including the last pulse cycle
			fault_sup_pkg::CH_RETRY: o_ch.gate_out = (cnt_r <= RW_LAST) && !i_ch.inhibit; // [RULE_07]
			default: o_ch.gate_out = 1'b0; // [RULE_04]
		endcase
	end

	// ==========================================================
	// Checks
	a_latch_holds_off: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE_04]
		state_r == fault_sup_pkg::CH_LATCHED |-> !o_ch.gate_out)
		else $error("Latched channel drives gate");
	a_mask_no_fault: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE_01]
		state_r == fault_sup_pkg::CH_ON_MASK |=> !fault_r || $past(state_r) != fault_sup_pkg::CH_ON_MASK)
		else $error("Fault set inside on mask");
	a_off_mask_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE_11]
		$past(state_r) == fault_sup_pkg::CH_OFF_MASK && state_r == fault_sup_pkg::CH_OFF_MASK |-> !fault_r)
		else $error("Open load reported in off mask");
	a_suppress_report: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE_15]
		state_r == fault_sup_pkg::CH_OFF_WATCH && !i_ch.report_en |=> !fault_r || state_r != fault_sup_pkg::CH_OFF_WATCH)
		else $error("Load fault reported during battery fault");
endmodule : fault_channel
`default_nettype wire

// File: predriver_fault_supervisor.sv
// Top level: four fault channels, battery lockout and fault flag
// Operation
// RULE_01 - Gate turning on starts a 60 us mask ignoring short detection.
// RULE_02 - After mask, steady high drain sets fault bit and flag.
// RULE_03 - Short deglitch interval is 8 us.
// RULE_04 - Latching variant holds gate off after short until cleared.
// RULE_05 - Off then on command clears the latched short fault.
// RULE_06 - Retry variant pulses gate until short gone or commanded off.
// RULE_07 - Retry period 10 ms, pulse width 68 us.
// RULE_08 - Retry variant restores gate and clears bit once short gone.
// RULE_09 - One fault bit per channel 0 to 3, read serially.
// RULE_10 - Open load is checked only while the gate is off.
// RULE_11 - Gate turning off starts a 60 us mask ignoring open load.
// RULE_12 - After off mask, low drain sets fault bit and flag.
// RULE_13 - Over-battery forces all gates off; recovery is automatic.
// RULE_14 - Over-battery raises the flag but no fault word bit.
// RULE_15 - Battery faults suppress load fault reporting.
// RULE_16 - Under-battery forces gates off, flags, sets no bits.
// RULE_17 - Battery fault gone before chip-select falls is not captured.
// RULE_18 - Chip-select fall releases flag if no fault remains.
// RULE_19 - Chip-select fall captures present fault bits for shifting.
// RULE_20 - Controller should do one serial access after power-up.
// RULE_21 - Synchronous comparator inputs, counted intervals, variant parameter.
`timescale 1ns/1ps
`default_nettype none
module predriver_fault_supervisor #(
	parameter logic VARIANT = fault_sup_pkg::VARIANT_LATCH,
	parameter logic UV_LOCKOUT = 1'b1,
	parameter int MASK_CYC = fault_sup_pkg::FAULT_MASK_CYC,
	parameter int DEGLITCH_CYC = fault_sup_pkg::SHORT_DEGLITCH_CYC,
	parameter int RETRY_PERIOD_CYC = fault_sup_pkg::RETRY_PERIOD_CYC,
	parameter int RETRY_PULSE_CYC = fault_sup_pkg::RETRY_PULSE_WIDTH_CYC
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [fault_sup_pkg::CHANNELS-1:0] i_cmd_on,
	input wire logic [fault_sup_pkg::CHANNELS-1:0] i_drain_sense,
	input wire logic i_bat_over,
	input wire logic i_bat_under,
	input wire logic i_cs_fall,
	output logic [fault_sup_pkg::CHANNELS-1:0] o_gate_out,
	output logic [fault_sup_pkg::CHANNELS-1:0] o_fault_bits,
	output logic [fault_sup_pkg::CHANNELS-1:0] o_fault_capture,
	output logic o_fault_flag_n_out,
	output logic o_fault_flag_n_oe
);
	localparam int N = fault_sup_pkg::CHANNELS;

	// ==========================================================
	// Battery lockout
	logic bat_fault;
	assign bat_fault = i_bat_over || (UV_LOCKOUT && i_bat_under); // [RULE_13] [RULE_16] [RULE_21]

	fault_sup_pkg::ch_in_t [N-1:0] ch_in;
	fault_sup_pkg::ch_out_t [N-1:0] ch_out;
	logic [N-1:0] gate_now;
	logic [N-1:0] fault_now;

	// ==========================================================
	// Channels
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_ch
			assign ch_in[g].cmd_on = i_cmd_on[g];
			assign ch_in[g].drain_high = i_drain_sense[g];
			assign ch_in[g].inhibit = bat_fault; // [RULE_13] [RULE_16]
			assign ch_in[g].report_en = !bat_fault; // [RULE_15]
			assign gate_now[g] = ch_out[g].gate_out;
			assign fault_now[g] = ch_out[g].fault; // [RULE_09]
			fault_channel #(
				.VARIANT(VARIANT),
				.MASK_CYC(MASK_CYC),
				.DEGLITCH_CYC(DEGLITCH_CYC),
				.RETRY_PERIOD_CYC(RETRY_PERIOD_CYC),
				.RETRY_PULSE_CYC(RETRY_PULSE_CYC)
			) u_ch (
				.i_clk(i_clk),
				.i_sys_rst(i_sys_rst),
				.i_ch(ch_in[g]),
				.o_ch(ch_out[g])
			);
		end
	endgenerate

	// ==========================================================
	// Flag and capture
	logic [N-1:0] gate_r, gate_nxt;
	logic [N-1:0] bits_r, bits_nxt;
	logic [N-1:0] cap_r, cap_nxt;
	logic flag_r, flag_nxt;
	logic bat_seen_r, bat_seen_nxt;

	always_comb begin
		gate_nxt = gate_now;
		bits_nxt = fault_now; // [RULE_14]
		cap_nxt = cap_r;
		// Battery events stay flagged until a chip-select fall, set beats release
		bat_seen_nxt = bat_seen_r || bat_fault;
		if (i_cs_fall) begin
			cap_nxt = fault_now; // [RULE_19] [RULE_17]
			bat_seen_nxt = bat_fault; // [RULE_18]
		end
		flag_nxt = (|fault_now) || bat_seen_nxt; // [RULE_02] [RULE_12] [RULE_14] [RULE_18]
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			gate_r <= 4'h0;
			bits_r <= 4'h0;
			cap_r <= 4'h0;
			flag_r <= 1'b0;
			bat_seen_r <= 1'b0;
		end else begin
			gate_r <= gate_nxt;
			bits_r <= bits_nxt;
			cap_r <= cap_nxt;
			flag_r <= flag_nxt;
			bat_seen_r <= bat_seen_nxt;
		end
	end

	// Open drain: drive low only while flagged
	assign o_gate_out = gate_r;
	assign o_fault_bits = bits_r;
	assign o_fault_capture = cap_r;
	assign o_fault_flag_n_out = 1'b0;
	assign o_fault_flag_n_oe = flag_r;

	// ==========================================================
	// Checks
	sequence s_bat_fault;
		bat_fault;
	endsequence
	sequence s_gates_dark;
		##1 (o_gate_out == 4'h0);
	endsequence
	a_bat_gates_off: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE_13]
		s_bat_fault |-> ##1 s_gates_dark)
		else $error("Gate on during battery fault");
	a_bat_flag_set: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE_14]
		bat_fault |=> o_fault_flag_n_oe)
		else $error("Battery fault not flagged");
	a_cs_capture: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE_19]
		i_cs_fall |=> o_fault_capture == $past(fault_now))
		else $error("Capture missed fault bits");
	a_flag_release: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RULE_18]
		i_cs_fall && !bat_fault && fault_now == 4'h0 |=> !o_fault_flag_n_oe)
		else $error("Flag held with no fault");
endmodule : predriver_fault_supervisor
`default_nettype wire

// File: mcu_model.sv
// Controller model that reads the captured fault word and the fault flag line
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
	input wire logic i_clk,
	input wire logic [fault_sup_pkg::CHANNELS-1:0] i_fault_capture,
	input wire logic i_fault_flag_n,
	output logic o_cs_fall
);
	// ==========================================================
	// Serial read
	initial o_cs_fall = 1'b0;
	// Word taken two cycles late so the capture register has settled
	task automatic read_word(output logic [fault_sup_pkg::CHANNELS-1:0] word, output logic flag_n);
		@(negedge i_clk);
		o_cs_fall = 1'b1;
		@(negedge i_clk);
		o_cs_fall = 1'b0;
		repeat (2) @(negedge i_clk);
		word = i_fault_capture;
		flag_n = i_fault_flag_n;
	endtask : read_word
endmodule : mcu_model
`default_nettype wire

// File: test_predriver_fault_supervisor.sv
// Self-checking bench for the predriver fault supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module test_predriver_fault_supervisor;
	// ==========================================================
	// Stimulus and wiring
	localparam int M = 20;
	localparam int D = 5;
	localparam int P = 100;
	localparam int W = 10;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [3:0] cmd_on = 4'h0;
	logic [3:0] drain = 4'hF;
	logic bat_over = 1'b0;
	logic bat_under = 1'b0;
	wire cs_fall;
	wire [3:0] gate, bits, cap, r_gate, r_bits;
	wire oe, f_out;
	// Open-drain flag with pull-up
	wire flag_n = oe ? f_out : 1'b1;
	int failures = 0;
	int comparisons = 0;
	int seed = 32'hEAE03AB2;
	int ch, oc, n;
	// ==========================================================
	// Reference model: battery memory and captured word
	int model_bat;
	int model_bits = 0;
	logic [3:0] cap_q[$];
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			model_bat <= 0;
		end else if (cs_fall) begin
			model_bat <= int'(bat_over || bat_under);
			cap_q.push_back(4'(model_bits));
		end else if (bat_over || bat_under) begin
			model_bat <= 1;
		end
	end
	always #5 i_clk = ~i_clk;
	predriver_fault_supervisor #(.VARIANT(fault_sup_pkg::VARIANT_LATCH), .UV_LOCKOUT(1'b1), .MASK_CYC(M),
		.DEGLITCH_CYC(D), .RETRY_PERIOD_CYC(P), .RETRY_PULSE_CYC(W)) DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_cmd_on(cmd_on), .i_drain_sense(drain), .i_bat_over(bat_over), .i_bat_under(bat_under),
		.i_cs_fall(cs_fall), .o_gate_out(gate), .o_fault_bits(bits), .o_fault_capture(cap),
		.o_fault_flag_n_out(f_out), .o_fault_flag_n_oe(oe));
	predriver_fault_supervisor #(.VARIANT(fault_sup_pkg::VARIANT_RETRY), .UV_LOCKOUT(1'b1), .MASK_CYC(M),
		.DEGLITCH_CYC(D), .RETRY_PERIOD_CYC(P), .RETRY_PULSE_CYC(W)) DUT_R (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_cmd_on(cmd_on), .i_drain_sense(drain), .i_bat_over(bat_over), .i_bat_under(bat_under),
		.i_cs_fall(cs_fall), .o_gate_out(r_gate), .o_fault_bits(r_bits), .o_fault_capture(),
		.o_fault_flag_n_out(), .o_fault_flag_n_oe());
	mcu_model PARTNER (.i_clk(i_clk), .i_fault_capture(cap), .i_fault_flag_n(flag_n), .o_cs_fall(cs_fall));
	// ==========================================================
	// Tasks
	task automatic cyc(input int k);
		repeat (k) @(negedge i_clk);
	endtask : cyc
	task automatic expect_out(input logic [3:0] g, input logic [3:0] b, input logic f);
		model_bits = int'(b);
		`CHK("gate", g, gate)
		`CHK("bits", b, bits)
		`CHK("flag", f, flag_n)
		`CHK("flag_model", (b == 4'h0 && model_bat == 0), flag_n)
	endtask : expect_out
	task automatic rd(input logic [3:0] w, input logic f);
		logic [3:0] word;
		logic fl;
		logic [3:0] exp_cap;
		PARTNER.read_word(word, fl);
		exp_cap = (cap_q.size() > 0) ? cap_q.pop_front() : 4'hX;
		`CHK("capture", w, word)
		`CHK("capture_model", exp_cap, word)
		`CHK("flag_read", f, fl)
	endtask : rd
	task automatic stop_test;
		if (failures == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test
	// ==========================================================
	// Watchdog, sized well above the expected run
	initial begin
		#200000;
		failures++;
		stop_test();
	end
	// ==========================================================
	// Main sequence
	initial begin
		cyc(3);
		i_sys_rst = 1'b0;
		cyc(1);
		expect_out(4'h0, 4'h0, 1'b1);
		rd(4'h0, 1'b1);
		ch = $unsigned($random(seed)) % 4;
		oc = (ch + 1) % 4;
		// Shorted load: drain high from the start, hidden by the mask
		cmd_on[ch] = 1'b1;
		cyc(M + 1);
		expect_out(4'(1 << ch), 4'h0, 1'b1);
		cyc(D + 6);
		expect_out(4'h0, 4'(1 << ch), 1'b0);
		rd(4'(1 << ch), 1'b0);
		cmd_on[ch] = 1'b0;
		cyc(3);
		drain[ch] = 1'b0;
		cmd_on[ch] = 1'b1;
		cyc(4);
		expect_out(4'(1 << ch), 4'h0, 1'b1);
		// Open load on the next channel
		cmd_on[oc] = 1'b1;
		cyc(3);
		drain[oc] = 1'b0;
		cmd_on[oc] = 1'b0;
		cyc(M - 2);
		expect_out(4'(1 << ch), 4'h0, 1'b1);
		cyc(8);
		expect_out(4'(1 << ch), 4'(1 << oc), 1'b0);
		drain[oc] = 1'b1;
		cyc(3);
		expect_out(4'(1 << ch), 4'h0, 1'b1);
		// Battery over and under, load faults present but suppressed
		cmd_on = 4'hF;
		drain = 4'h0;
		cyc(M + D + 4);
		for (n = 0; n < 2; n++) begin
			if (n == 0) begin
				bat_over = 1'b1;
			end else begin
				bat_under = 1'b1;
			end
			cyc(4);
			expect_out(4'h0, 4'h0, 1'b0);
			cyc(M + D + 6);
			expect_out(4'h0, 4'h0, 1'b0);
			drain = 4'hF;
			cyc(1);
			bat_over = 1'b0;
			bat_under = 1'b0;
			cyc(3);
			drain = 4'h0;
			cyc(1);
			expect_out(4'hF, 4'h0, 1'b0);
			rd(4'h0, 1'b1);
		end
		// Retry variant: pulse shape, then recovery
		cmd_on = 4'h0;
		drain = 4'hF;
		i_sys_rst = 1'b1;
		cyc(3);
		i_sys_rst = 1'b0;
		cmd_on[0] = 1'b1;
		cyc(M + D + 6);
		`CHK("retry_bit", 4'h1, r_bits)
		n = 0;
		while (r_gate[0] === 1'b1 && n < 2 * P) begin n++; cyc(1); end
		n = 0;
		while (r_gate[0] !== 1'b1 && n < 2 * P) begin n++; cyc(1); end
		n = 0;
		while (r_gate[0] === 1'b1 && n < 2 * P) begin n++; cyc(1); end
		`CHK("pulse_width", W, n)
		n = 0;
		while (r_gate[0] !== 1'b1 && n < 2 * P) begin n++; cyc(1); end
		`CHK("pulse_gap", P - W, n)
		drain[0] = 1'b0;
		cyc(2 * P);
		`CHK("retry_gate", 4'h1, r_gate)
		`CHK("retry_clear", 4'h0, r_bits)
		stop_test();
	end
endmodule : test_predriver_fault_supervisor
`default_nettype wire
